// >>> shared/fwp_pkg.sv
/*
  Constants for the flash resume, write-enable and block-protect logic:
  opcodes, frame byte counts, array geometry, reset values, sequencer kinds.
  Assumes a 512 KB array addressed with 19 bits.
*/
`default_nettype none
package fwp_pkg;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_ERASE4K = 8'h20;
  localparam logic [7:0] OP_ERASE32K = 8'h52;
  localparam logic [7:0] OP_ERASE64K = 8'hd8;
  localparam logic [7:0] OP_CHIP1 = 8'h60;
  localparam logic [7:0] OP_CHIP2 = 8'hc7;
  localparam logic [7:0] OP_SEC_PROG = 8'h42;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  // Whole bytes a frame needs: opcode, opcode plus data, opcode plus address
  localparam logic [2:0] BYTES_OPCODE = 3'h1;
  localparam logic [2:0] BYTES_WRSR = 3'h2;
  localparam logic [2:0] BYTES_ADDR = 3'h4;
  localparam logic [2:0] BYTES_MAX = 3'h7;
  // Array geometry, region masks are size minus one
  localparam logic [18:0] ARRAY_LAST = 19'h7ffff;
  localparam logic [18:0] MASK_PAGE = 19'h000ff;
  localparam logic [18:0] MASK_4K = 19'h00fff;
  localparam logic [18:0] MASK_8K = 19'h01fff;
  localparam logic [18:0] MASK_16K = 19'h03fff;
  localparam logic [18:0] MASK_32K = 19'h07fff;
  localparam logic [18:0] MASK_64K = 19'h0ffff;
  localparam logic [18:0] MASK_128K = 19'h1ffff;
  localparam logic [18:0] MASK_256K = 19'h3ffff;
  // Field layout of the status-write data byte
  localparam int CMP_POS = 5;
  localparam int BP_LSB = 0;
  localparam logic [5:0] PROT_RESET = 6'h00;
  typedef enum logic [1:0] {
    FWP_FR_IDLE = 2'b01,
    FWP_FR_SHIFT = 2'b10
  } fwp_frame_type;
  typedef enum logic [2:0] {
    FWP_K_PROG = 3'h0,
    FWP_K_ERASE = 3'h1,
    FWP_K_CHIP = 3'h2,
    FWP_K_SEC_PROG = 3'h3,
    FWP_K_SEC_ERASE = 3'h4
  } fwp_kind_type;
endpackage
`default_nettype wire

// >>> rtl/fwp_core.sv
/*
  Command handling for resume, write enable/disable and block protection
  of a serial flash, with the launch of program and erase commands.
  Assumes SPI mode 0/3 pins arriving asynchronously, sampled on sys_clk
  well above the serial clock, and an array sequencer that reports
  completion and resume acknowledgement as one-cycle pulses.
*/
`default_nettype none
module fwp_core (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // Serial pins
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic write_protect_n,
  // Array sequencer
  input wire logic seq_done,
  input wire logic seq_resume_ack,
  output logic seq_start,
  output fwp_pkg::fwp_kind_type seq_kind,
  output logic [18:0] seq_addr,
  output logic seq_resume,
  output logic seq_resume_erase,
  output logic seq_suspend,
  // Status
  output logic write_enable_latch,
  output logic erase_suspended_flag,
  output logic program_suspended_flag,
  output logic operation_in_progress_flag,
  output logic protect_complement_bit,
  output logic block_protect_top_bit,
  output logic block_protect_side_bit,
  output logic block_protect_bit2,
  output logic block_protect_bit1,
  output logic block_protect_bit0
);
  logic [3:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r, pin_agree;
  logic sck_rise, cs_fall, cs_rise, resuming_r, cur_erase_r, cur_chip_r;
  fwp_pkg::fwp_frame_type frame_r;
  logic [2:0] bit_mod_r, nbytes_r;
  logic [17:0] shift_r;
  logic [7:0] opcode_r, data_r;
  logic [18:0] addr_r;
  logic [5:0] prot_r;
  logic frame_ok, is_wren, is_wrdi, is_resume, is_susp, wr_try, prot_refuse, wrsr_go, start_go;
  logic addr_cmd, chip_cmd, wrsr_cmd, sec_cmd, len_ok, susp_allow;
  logic p_none, p_all, p_upper, pr_none, hit;
  logic [18:0] p_mask, plo, phi, tmask, tlo, thi;
  fwp_pkg::fwp_kind_type kind;

  // Three-stage sync; a level counts once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pin_s1_r <= 4'h3;
      pin_s2_r <= 4'h3;
      pin_s3_r <= 4'h3;
      pin_f_r <= 4'h3;
    end else if (ce) begin
      pin_s1_r <= {spi_mosi, spi_sck, spi_cs_n, write_protect_n};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_f_r <= (pin_f_r & ~pin_agree) | (pin_s3_r & pin_agree);
    end
  end
  assign pin_agree = ~(pin_s2_r ^ pin_s3_r);
  assign sck_rise = ce && pin_agree[2] && pin_s3_r[2] && !pin_f_r[2];
  assign cs_fall = ce && pin_agree[1] && !pin_s3_r[1] && pin_f_r[1];
  assign cs_rise = ce && pin_agree[1] && pin_s3_r[1] && !pin_f_r[1]
    && frame_r == fwp_pkg::FWP_FR_SHIFT;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      frame_r <= fwp_pkg::FWP_FR_IDLE;
    end else if (ce) begin
      case (frame_r)
        fwp_pkg::FWP_FR_IDLE: if (cs_fall) frame_r <= fwp_pkg::FWP_FR_SHIFT;
        fwp_pkg::FWP_FR_SHIFT: if (cs_rise) frame_r <= fwp_pkg::FWP_FR_IDLE;
        default: frame_r <= fwp_pkg::FWP_FR_IDLE;
      endcase
    end
  end

  // Bit and byte counting; bytes past those captured are ignored
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bit_mod_r <= 3'h0;
      nbytes_r <= 3'h0;
      shift_r <= 18'h0;
      opcode_r <= 8'h00;
      data_r <= 8'h00;
      addr_r <= 19'h0;
    end else if (cs_fall) begin
      bit_mod_r <= 3'h0;
      nbytes_r <= 3'h0;
    end else if (sck_rise && frame_r == fwp_pkg::FWP_FR_SHIFT) begin
      shift_r <= {shift_r[16:0], pin_f_r[3]};
      bit_mod_r <= bit_mod_r + 3'h1;
      if (bit_mod_r == 3'h7) begin
        if (nbytes_r != fwp_pkg::BYTES_MAX) nbytes_r <= nbytes_r + 3'h1;
        if (nbytes_r == 3'h0) opcode_r <= {shift_r[6:0], pin_f_r[3]};
        if (nbytes_r == 3'h1) data_r <= {shift_r[6:0], pin_f_r[3]};
        if (nbytes_r == 3'h3) addr_r <= {shift_r[17:0], pin_f_r[3]};
      end
    end
  end

  // Whole opcode received and frame closed on a byte boundary
  assign frame_ok = cs_rise && bit_mod_r == 3'h0 && nbytes_r >= fwp_pkg::BYTES_OPCODE;
  assign is_wren = frame_ok && opcode_r == fwp_pkg::OP_WREN;
  assign is_wrdi = frame_ok && opcode_r == fwp_pkg::OP_WRDI;
  assign is_resume = frame_ok && opcode_r == fwp_pkg::OP_RESUME
    && !operation_in_progress_flag
    && (erase_suspended_flag || program_suspended_flag);
  // Chip erase cannot be halted, nor a program while an erase is parked
  assign is_susp = frame_ok && opcode_r == fwp_pkg::OP_SUSPEND
    && operation_in_progress_flag && !resuming_r && !cur_chip_r
    && (cur_erase_r || !erase_suspended_flag);

  always_comb begin
    addr_cmd = 1'b1;
    kind = fwp_pkg::FWP_K_ERASE;
    tmask = fwp_pkg::MASK_4K;
    if (opcode_r == fwp_pkg::OP_PROG) begin
      kind = fwp_pkg::FWP_K_PROG;
      tmask = fwp_pkg::MASK_PAGE;
    end else if (opcode_r == fwp_pkg::OP_ERASE4K) begin
      tmask = fwp_pkg::MASK_4K;
    end else if (opcode_r == fwp_pkg::OP_ERASE32K) begin
      tmask = fwp_pkg::MASK_32K;
    end else if (opcode_r == fwp_pkg::OP_ERASE64K) begin
      tmask = fwp_pkg::MASK_64K;
    end else if (opcode_r == fwp_pkg::OP_SEC_PROG) begin
      kind = fwp_pkg::FWP_K_SEC_PROG;
    end else if (opcode_r == fwp_pkg::OP_SEC_ERASE) begin
      kind = fwp_pkg::FWP_K_SEC_ERASE;
    end else begin
      addr_cmd = 1'b0;
      kind = fwp_pkg::FWP_K_CHIP;
      tmask = fwp_pkg::ARRAY_LAST;
    end
  end
  assign chip_cmd = opcode_r == fwp_pkg::OP_CHIP1 || opcode_r == fwp_pkg::OP_CHIP2;
  assign wrsr_cmd = opcode_r == fwp_pkg::OP_WRSR;
  assign sec_cmd = kind == fwp_pkg::FWP_K_SEC_PROG || kind == fwp_pkg::FWP_K_SEC_ERASE;
  assign len_ok = addr_cmd ? nbytes_r >= fwp_pkg::BYTES_ADDR
    : wrsr_cmd ? nbytes_r >= fwp_pkg::BYTES_WRSR : chip_cmd;
  // While parked, only a program may run, and only beside a parked erase
  assign susp_allow = !program_suspended_flag
    && (!erase_suspended_flag || kind == fwp_pkg::FWP_K_PROG
    || kind == fwp_pkg::FWP_K_SEC_PROG);
  assign tlo = addr_r & ~tmask;
  assign thi = addr_r | tmask;
  // Protected fraction from the block-protect bits
  always_comb begin
    p_none = 1'b0;
    p_all = 1'b0;
    p_upper = !prot_r[3];
    p_mask = fwp_pkg::MASK_64K;
    if (prot_r[2:0] == 3'h0) begin
      p_none = 1'b1;
    end else if (!prot_r[4]) begin
      if (prot_r[2]) p_all = 1'b1;
      else if (prot_r[1:0] == 2'h1) p_mask = fwp_pkg::MASK_64K;
      else if (prot_r[1:0] == 2'h2) p_mask = fwp_pkg::MASK_128K;
      else p_mask = fwp_pkg::MASK_256K;
    end else begin
      case (prot_r[2:0])
        3'h1: p_mask = fwp_pkg::MASK_4K;
        3'h2: p_mask = fwp_pkg::MASK_8K;
        3'h3: p_mask = fwp_pkg::MASK_16K;
        3'h7: p_all = 1'b1;
        default: p_mask = fwp_pkg::MASK_32K;
      endcase
    end
  end

  // Complement takes the rest of the array, none and all swap
  always_comb begin
    pr_none = 1'b0;
    plo = 19'h0;
    phi = fwp_pkg::ARRAY_LAST;
    if (!prot_r[fwp_pkg::CMP_POS]) begin
      pr_none = p_none;
      if (!p_all && p_upper) plo = fwp_pkg::ARRAY_LAST - p_mask;
      if (!p_all && !p_upper) phi = p_mask;
    end else begin
      pr_none = p_all;
      if (!p_none && p_upper) phi = fwp_pkg::ARRAY_LAST - p_mask - 19'h1;
      if (!p_none && !p_upper) plo = p_mask + 19'h1;
    end
  end
  // Current bits at frame end decide the outcome
  assign hit = !pr_none && tlo <= phi && thi >= plo;
  assign wr_try = frame_ok && (addr_cmd || chip_cmd || wrsr_cmd) && len_ok
    && !operation_in_progress_flag && write_enable_latch && susp_allow;
  assign prot_refuse = wr_try && !wrsr_cmd && !sec_cmd && hit;
  // Status write is refused while suspended and while the pin locks it
  assign wrsr_go = wr_try && wrsr_cmd && !erase_suspended_flag
    && !program_suspended_flag && pin_f_r[0];
  assign start_go = wr_try && !wrsr_cmd && !prot_refuse;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      write_enable_latch <= 1'b0;
    end else if (is_wren) begin
      write_enable_latch <= 1'b1;
    end else if (is_wrdi || prot_refuse || wrsr_go) begin
      write_enable_latch <= 1'b0;
    end else if (start_go) begin
      write_enable_latch <= 1'b0;
    end
  end
  // Non-volatile in the array; here a defined value after reset
  always_ff @(posedge sys_clk) begin
    if (!rstn) prot_r <= fwp_pkg::PROT_RESET;
    else if (wrsr_go) prot_r <= data_r[fwp_pkg::CMP_POS:fwp_pkg::BP_LSB];
  end
  assign {protect_complement_bit, block_protect_top_bit, block_protect_side_bit,
    block_protect_bit2, block_protect_bit1, block_protect_bit0} = prot_r;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      operation_in_progress_flag <= 1'b0;
      cur_erase_r <= 1'b0;
      cur_chip_r <= 1'b0;
    end else if (start_go) begin
      operation_in_progress_flag <= 1'b1;
      cur_erase_r <= kind != fwp_pkg::FWP_K_PROG && kind != fwp_pkg::FWP_K_SEC_PROG;
      cur_chip_r <= kind == fwp_pkg::FWP_K_CHIP;
    end else if (is_resume) begin
      operation_in_progress_flag <= 1'b1;
      cur_erase_r <= !program_suspended_flag;
      cur_chip_r <= 1'b0;
    end else if (is_susp || (ce && seq_done)) begin
      operation_in_progress_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      erase_suspended_flag <= 1'b0;
      program_suspended_flag <= 1'b0;
    end else if (is_susp) begin
      if (cur_erase_r) erase_suspended_flag <= 1'b1;
      else program_suspended_flag <= 1'b1;
    end else if (is_resume) begin
      if (program_suspended_flag) program_suspended_flag <= 1'b0;
      else erase_suspended_flag <= 1'b0;
    end
  end
  // Set wins over the acknowledgement; a finish also ends it, so no stale lock
  always_ff @(posedge sys_clk) begin
    if (!rstn) resuming_r <= 1'b0;
    else if (is_resume) resuming_r <= 1'b1;
    else if (ce && (seq_resume_ack || seq_done)) resuming_r <= 1'b0;
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      seq_start <= 1'b0;
      seq_kind <= fwp_pkg::FWP_K_PROG;
      seq_addr <= 19'h0;
      seq_resume <= 1'b0;
      seq_resume_erase <= 1'b0;
      seq_suspend <= 1'b0;
    end else if (ce) begin
      seq_start <= start_go;
      seq_resume <= is_resume;
      seq_suspend <= is_susp;
      if (start_go) begin
        seq_kind <= kind;
        seq_addr <= addr_r;
      end
      if (is_resume) seq_resume_erase <= !program_suspended_flag;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wel_set_a: assert property (is_wren |=> write_enable_latch)
    else $error("write enable did not set latch");
  wel_clear_a: assert property (is_wrdi |=> !write_enable_latch)
    else $error("write disable did not clear latch");
  wel_keep_a: assert property (cs_rise && !frame_ok |=> $stable(write_enable_latch))
    else $error("latch changed on a bad frame");
  resume_gate_a: assert property (seq_resume |-> $past(!operation_in_progress_flag)
    && $past(erase_suspended_flag || program_suspended_flag))
    else $error("resume issued while not allowed");
  resume_busy_a: assert property (seq_resume |-> operation_in_progress_flag
    && !$past(resuming_r, 2))
    else $error("resume did not show busy");
  prog_first_a: assert property (seq_resume && $past(program_suspended_flag, 2)
    |-> !seq_resume_erase && erase_suspended_flag == $past(erase_suspended_flag, 2))
    else $error("program not resumed first");
  susp_block_a: assert property (resuming_r && frame_ok
    && opcode_r == fwp_pkg::OP_SUSPEND |=> !seq_suspend)
    else $error("suspend taken while resuming");
  start_wel_a: assert property (seq_start |-> $past(write_enable_latch)
    && !write_enable_latch)
    else $error("write started without latch");
  start_prot_a: assert property (seq_start && seq_kind != fwp_pkg::FWP_K_SEC_PROG
    && seq_kind != fwp_pkg::FWP_K_SEC_ERASE |-> !$past(hit))
    else $error("write started into protected range");
  prot_hold_a: assert property (!wrsr_go |=> $stable(prot_r))
    else $error("protect bits changed without status write");
  wp_lock_a: assert property (frame_ok && wrsr_cmd && !pin_f_r[0] |=> $stable(prot_r))
    else $error("protect bits changed while locked");
  susp_flag_a: assert property (seq_suspend |-> !operation_in_progress_flag
    && (erase_suspended_flag || program_suspended_flag))
    else $error("suspend did not flag and go ready");
  wren_c: cover property (is_wren ##[1:1000] start_go);
  resume_c: cover property (seq_suspend ##[1:1000] seq_resume);
  refuse_c: cover property (prot_refuse);
  both_c: cover property (erase_suspended_flag && program_suspended_flag ##[1:1000] seq_resume);
endmodule
`default_nettype wire

// >>> test/fwp_spi_host.sv
/*
  Host controller model for the flash command block: frames opcodes and
  data bytes with chip select, mode 0 serial clock, MSB first.
  Assumes sys_clk paces it; the serial clock idles low outside frames.
*/
`default_nettype none
module fwp_spi_host (
  // Reference clock
  input wire logic sys_clk,
  // Serial pins
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // Data left-aligned; nbits may stop short or off a byte boundary
  task automatic send(input logic [39:0] data, input int nbits);
    @(posedge sys_clk);
    spi_cs_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_mosi <= data[39-i];
      repeat (4) @(posedge sys_clk);
      spi_sck <= 1'b1;
      repeat (4) @(posedge sys_clk);
      spi_sck <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    spi_cs_n <= 1'b1;
    // Released line: inverse of the last bit, so a stale value never looks valid
    spi_mosi <= ~spi_mosi;
    repeat (10) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// >>> test/flash_resume_wel_protect_tb_top.sv
/*
  Self-checking bench for fwp_core: latch, resume and protection commands
  sent through the host model, sequencer pulses driven here.
  Assumes the outputs settle within 10 sys_clk after chip select rises.
*/
`default_nettype none
module flash_resume_wel_protect_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic write_protect_n = 1'b1;
  logic seq_done = 1'b0;
  logic seq_resume_ack = 1'b0;
  logic spi_sck, spi_cs_n, spi_mosi;
  logic seq_start, seq_resume, seq_resume_erase, seq_suspend;
  fwp_pkg::fwp_kind_type seq_kind;
  logic [18:0] seq_addr;
  logic wel, esus, psus, busy;
  logic [5:0] prot;
  int n_fail = 0;
  int n_compared = 0;
  int n_start = 0;
  int n_res = 0;
  int n_susp = 0;
  int n0;
  logic res_erase = 1'b0;
  logic [7:0] t_op [13] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02,
    8'hd8, 8'h02, 8'h02, 8'h02, 8'h02};
  logic [7:0] t_sr [13] = '{8'h01, 8'h01, 8'h09, 8'h09, 8'h04, 8'h11, 8'h19, 8'h15,
    8'h11, 8'h21, 8'h21, 8'h24, 8'h31};
  logic [18:0] t_ad [13] = '{19'h70000, 19'h6ff00, 19'h0ff00, 19'h10000, 19'h00000,
    19'h7f000, 19'h01000, 19'h77f00, 19'h70000, 19'h6ff00, 19'h70000, 19'h00000,
    19'h7f000};
  logic t_ok [13] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0,
    1'b1, 1'b1, 1'b1};

  always #10 sys_clk = ~sys_clk;

  fwp_spi_host i_fwp_spi_host (.sys_clk(sys_clk), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));

  fwp_core i_fwp_core (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .write_protect_n(write_protect_n),
    .seq_done(seq_done), .seq_resume_ack(seq_resume_ack), .seq_start(seq_start),
    .seq_kind(seq_kind), .seq_addr(seq_addr), .seq_resume(seq_resume),
    .seq_resume_erase(seq_resume_erase), .seq_suspend(seq_suspend),
    .write_enable_latch(wel), .erase_suspended_flag(esus),
    .program_suspended_flag(psus), .operation_in_progress_flag(busy),
    .protect_complement_bit(prot[5]), .block_protect_top_bit(prot[4]),
    .block_protect_side_bit(prot[3]), .block_protect_bit2(prot[2]),
    .block_protect_bit1(prot[1]), .block_protect_bit0(prot[0]));

  // Pulses last one cycle, so they are counted as they happen
  always @(posedge sys_clk) begin
    if (seq_start === 1'b1) n_start++;
    if (seq_suspend === 1'b1) n_susp++;
    if (seq_resume === 1'b1) begin
      n_res++;
      res_erase = seq_resume_erase;
    end
  end

  task automatic chk(input string name, input logic [18:0] exp, input logic [18:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("Counts: %0d compared, %0d failed", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op, input int bits);
    i_fwp_spi_host.send({op, 32'h0}, bits);
  endtask

  task automatic addr_cmd(input logic [7:0] op, input logic [18:0] a);
    i_fwp_spi_host.send({op, 5'h0, a, 8'h0}, 32);
  endtask

  // Ack when ack is set, otherwise completion
  task automatic seq_pulse(input logic ack);
    @(posedge sys_clk);
    if (ack) seq_resume_ack <= 1'b1;
    else seq_done <= 1'b1;
    @(posedge sys_clk);
    seq_resume_ack <= 1'b0;
    seq_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk);
    n_fail++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("status", 19'h0, 19'({wel, esus, psus, busy, prot}));
    cmd(fwp_pkg::OP_WREN, 7);
    chk("latch", 19'h0, 19'(wel));
    cmd(fwp_pkg::OP_WREN, 8);
    chk("latch", 19'h1, 19'(wel));
    cmd(fwp_pkg::OP_WRDI, 12);
    chk("latch", 19'h1, 19'(wel));
    cmd(fwp_pkg::OP_WRDI, 16);
    chk("latch", 19'h0, 19'(wel));
    $display("test latch done");
    cmd(fwp_pkg::OP_RESUME, 8);
    chk("resumes", 19'h0, 19'(n_res));
    addr_cmd(fwp_pkg::OP_PROG, 19'h12345);
    chk("starts", 19'h0, 19'(n_start));
    cmd(fwp_pkg::OP_WREN, 8);
    addr_cmd(fwp_pkg::OP_PROG, 19'h12345);
    chk("starts", 19'h1, 19'(n_start));
    chk("addr", 19'h12345, seq_addr);
    chk("busy latch", 19'h2, 19'({busy, wel}));
    cmd(fwp_pkg::OP_SUSPEND, 8);
    chk("psus busy", 19'h2, 19'({psus, busy}));
    cmd(fwp_pkg::OP_RESUME, 7);
    cmd(fwp_pkg::OP_RESUME, 12);
    chk("resumes", 19'h0, 19'(n_res));
    cmd(fwp_pkg::OP_RESUME, 16);
    chk("resumes", 19'h1, 19'(n_res));
    chk("psus busy kind", 19'h2, 19'({psus, busy, res_erase}));
    cmd(fwp_pkg::OP_SUSPEND, 8);
    chk("suspends", 19'h1, 19'(n_susp));
    cmd(fwp_pkg::OP_RESUME, 8);
    chk("resumes", 19'h1, 19'(n_res));
    seq_pulse(1'b1);
    seq_pulse(1'b0);
    cmd(fwp_pkg::OP_WREN, 8);
    addr_cmd(fwp_pkg::OP_ERASE4K, 19'h20000);
    chk("kind", 19'(fwp_pkg::FWP_K_ERASE), 19'(seq_kind));
    cmd(fwp_pkg::OP_SUSPEND, 8);
    chk("esus", 19'h1, 19'(esus));
    cmd(fwp_pkg::OP_WREN, 8);
    addr_cmd(fwp_pkg::OP_PROG, 19'h12345);
    cmd(fwp_pkg::OP_SUSPEND, 8);
    chk("suspends", 19'h2, 19'(n_susp));
    chk("esus busy", 19'h3, 19'({esus, busy}));
    seq_pulse(1'b0);
    cmd(fwp_pkg::OP_RESUME, 8);
    chk("esus busy kind", 19'h3, 19'({esus, busy, res_erase}));
    seq_pulse(1'b1);
    seq_pulse(1'b0);
    $display("test resume done");
    i_fwp_spi_host.send({fwp_pkg::OP_WRSR, 8'h04, 24'h0}, 16);
    chk("protect", 19'h0, 19'(prot));
    cmd(fwp_pkg::OP_WREN, 8);
    write_protect_n <= 1'b0;
    i_fwp_spi_host.send({fwp_pkg::OP_WRSR, 8'h04, 24'h0}, 16);
    chk("protect latch", 19'h1, 19'({prot, wel}));
    write_protect_n <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      cmd(fwp_pkg::OP_WREN, 8);
      i_fwp_spi_host.send({fwp_pkg::OP_WRSR, t_sr[i], 24'h0}, 16);
      chk("protect", 19'(t_sr[i][5:0]), 19'(prot));
      cmd(fwp_pkg::OP_WREN, 8);
      n0 = n_start;
      addr_cmd(t_op[i], t_ad[i]);
      chk("protected start", 19'(t_ok[i]), 19'(n_start - n0));
      if (t_ok[i]) seq_pulse(1'b0);
    end
    $display("test protect done");
    end_of_test();
  end
endmodule
`default_nettype wire
